// [logic/linear11_to_raw.sv]
`timescale 1ns/100ps
// linear11 word to an unsigned value in the same 62.5 mA unit as the averaged current
module linear11_to_raw
    import pmbank_pkg::*;
(
    input  wire logic [15:0] word,
    output logic      [15:0] raw
);
    logic signed [4:0]  exp_s;
    logic        [10:0] mant;
    logic signed [5:0]  shift_s;

    always_comb begin
        exp_s   = signed'(word[15:LINEAR_EXP_LSB]);
        mant    = word[AVG_OC_LIMIT_MANT_W-1:0];
        // telemetry unit is 2^-4 A; shift mantissa by (exp + 4), one bit wider so it cannot wrap
        shift_s = 6'(exp_s) + 6'sd4;
        if (shift_s >= 6'sd0) begin
            raw = 16'(mant) << shift_s;
        end else begin
            raw = 16'(mant) >> (-shift_s);
        end
    end
endmodule // linear11_to_raw

// [logic/pmbank_pkg.sv]
package pmbank_pkg;
    // ========================================================
    // command codes
    localparam logic [7:0] CMD_STARTUP_TIMEOUT_ACTION = 8'h63;
    localparam logic [7:0] CMD_POWER_DOWN_DELAY       = 8'h64;
    localparam logic [7:0] CMD_POWER_DOWN_RAMP        = 8'h65;
    localparam logic [7:0] CMD_STATUS_BYTE            = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD            = 8'h79;
    localparam logic [7:0] CMD_VOUT_STATUS            = 8'h7A;
    localparam logic [7:0] CMD_IOUT_STATUS            = 8'h7B;
    localparam logic [7:0] CMD_INPUT_STATUS           = 8'h7C;
    localparam logic [7:0] CMD_TEMP_STATUS            = 8'h7D;
    localparam logic [7:0] CMD_CML_STATUS             = 8'h7E;
    localparam logic [7:0] CMD_VENDOR_STATUS          = 8'h80;
    localparam logic [7:0] CMD_VIN_READING            = 8'h88;
    localparam logic [7:0] CMD_IIN_READING            = 8'h89;
    localparam logic [7:0] CMD_VOUT_READING           = 8'h8B;
    localparam logic [7:0] CMD_IOUT_READING           = 8'h8C;
    localparam logic [7:0] CMD_TEMP_READING           = 8'h8D;
    localparam logic [7:0] CMD_FREQ_READING           = 8'h95;
    localparam logic [7:0] CMD_PROTOCOL_REVISION      = 8'h98;
    localparam logic [7:0] CMD_MAKER_ID               = 8'h99;
    localparam logic [7:0] CMD_MODEL_ID               = 8'h9A;
    localparam logic [7:0] CMD_MAKER_REVISION         = 8'h9B;
    localparam logic [7:0] CMD_SERIAL_ID              = 8'h9E;
    localparam logic [7:0] CMD_MIN_VOUT               = 8'hA4;
    localparam logic [7:0] CMD_MAX_VOUT               = 8'hA5;
    localparam logic [7:0] CMD_CHIP_ID                = 8'hAD;
    localparam logic [7:0] CMD_CHIP_REVISION          = 8'hAE;
    localparam logic [7:0] CMD_AVG_OC_ACTION          = 8'hC4;
    localparam logic [7:0] CMD_AVG_OC_LIMIT           = 8'hC5;
    localparam logic [7:0] CMD_PCT_VOUT_LIMITS        = 8'hC6;
    localparam logic [7:0] CMD_PCT_PGOOD              = 8'hC7;
    localparam logic [7:0] CMD_VENDOR_MODE            = 8'hC8;
    localparam logic [7:0] CMD_BUS_BASE_ADDRESS       = 8'hC9;
    localparam logic [7:0] CMD_SECOND_MAKER_ID        = 8'hCA;
    // ========================================================
    // reset values
    localparam logic [7:0]  RST_STARTUP_TIMEOUT_ACTION = 8'h80;
    localparam logic [15:0] RST_POWER_DOWN_DELAY       = 16'h0000;
    localparam logic [15:0] RST_POWER_DOWN_RAMP        = 16'h0005;
    localparam logic [15:0] RST_MIN_VOUT               = 16'h0100;
    localparam logic [15:0] RST_MAX_VOUT               = 16'h0B01;
    localparam logic [7:0]  RST_AVG_OC_ACTION          = 8'h80;
    localparam logic [15:0] RST_AVG_OC_LIMIT           = 16'hE340;
    localparam logic [15:0] RST_PCT_VOUT_LIMITS        = 16'h06E0;
    localparam logic [7:0]  RST_PCT_PGOOD              = 8'h19;
    localparam logic [7:0]  RST_VENDOR_MODE            = 8'hA0;
    localparam logic [6:0]  RST_BUS_BASE_ADDRESS       = 7'h10;
    // identity defaults: arbitrary neutral values
    localparam logic [7:0]  ID_PROTOCOL_REVISION       = 8'h11;
    localparam logic [7:0]  ID_DATA_BYTE               = 8'h5A;
    localparam logic [15:0] ID_SECOND_MAKER            = 16'h1234;
    // ========================================================
    // block format and fields
    localparam logic [7:0]  BLOCK_COUNT                = 8'h01;
    localparam int          MODE_VOLTAGE_SET_PIN_BIT   = 0;
    localparam int          MODE_LSW_OVW_BIT           = 1;
    localparam int          MODE_DCM_BIT               = 2;
    localparam int          MODE_RSENSE_LSB            = 4;
    localparam int          VSTAT_NVM_FAULT_BIT        = 1;
    localparam int          AVG_OC_LIMIT_MANT_W        = 11;
    localparam int          LINEAR_EXP_LSB             = 11;
endpackage

// [logic/power_management_command_bank.sv]
`timescale 1ns/100ps
// How it works
// RULE1: seven-bit bus base address register, resets to 10h, host reads and writes it.
// RULE2: averaged current over the 62.5 mA-step limit (default 52 A) raises the fault action.
// RULE3: vendor mode bit chooses the voltage-set pin as target source; resets to A0h.
// RULE4: vendor mode bits pick low-side switch at overvoltage warning, and conduction mode.
// RULE5: vendor mode bits 7:4 select the input current sense resistor.
// RULE6: host disables regulation before and during any setting change.
// RULE7: host disables regulation before storing or restoring non-volatile settings.
// RULE8: start-up memory fault pulls alert low and sets vendor status bit 1.
// RULE9: second maker identifier is a 16-bit word register, all bits stored.
// RULE10: block identifiers read back count 01h then one byte; other counts refused.
// RULE11: status and telemetry registers ignore host writes.
module power_management_command_bank
    import pmbank_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  cmd,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    output logic             cmd_unmapped,
    output logic             wr_refused,
    input  wire logic        nvm_fault_pin,
    input  wire logic        startup_done,
    input  wire logic [15:0] avg_current,
    input  wire logic        avg_current_valid,
    input  wire logic [7:0]  status_byte_in,
    input  wire logic [15:0] status_word_in,
    input  wire logic [7:0]  vout_status_in,
    input  wire logic [7:0]  iout_status_in,
    input  wire logic [7:0]  input_status_in,
    input  wire logic [7:0]  temp_status_in,
    input  wire logic [7:0]  cml_status_in,
    input  wire logic [15:0] vin_reading,
    input  wire logic [15:0] iin_reading,
    input  wire logic [15:0] vout_reading,
    input  wire logic [15:0] iout_reading,
    input  wire logic [15:0] temp_reading,
    input  wire logic [15:0] freq_reading,
    output logic             alert_output_n,
    output logic             avg_overcurrent_fault,
    output logic [7:0]       avg_overcurrent_action,
    output logic [7:0]       startup_timeout_fault_action,
    output logic [15:0]      power_down_delay,
    output logic [15:0]      power_down_ramp_time,
    output logic [15:0]      percent_output_voltage_limits,
    output logic [7:0]       percent_power_good_thresholds,
    output logic             voltage_set_pin_select,
    output logic             low_side_switch_at_overvoltage_warning,
    output logic             discontinuous_conduction,
    output logic [3:0]       input_current_sense_resistor,
    output logic [6:0]       bus_base_address
);
    // ========================================================
    // state
    typedef struct packed {
        logic [7:0]  startup_timeout_action;
        logic [15:0] power_down_delay;
        logic [15:0] power_down_ramp;
        logic [7:0]  avg_oc_action;
        logic [15:0] avg_oc_limit;
        logic [15:0] pct_vout_limits;
        logic [7:0]  pct_pgood;
        logic [7:0]  vendor_mode;
        logic [6:0]  base_address;
        logic [7:0]  maker_id;
        logic [7:0]  model_id;
        logic [7:0]  serial_id;
        logic [15:0] second_maker_id;
        logic        nvm_fault;
        logic        avg_oc_fault;
        logic        fault_s1;
        logic        fault_s2;
        logic        done_s1;
        logic        done_s2;
        logic [15:0] rd_data;
        logic        rd_valid;
        logic        unmapped;
        logic        refused;
    } state_s;

    state_s      st_q;
    state_s      st_d;
    logic [15:0] limit_raw;

    linear11_to_raw u_limit (
        .word (st_q.avg_oc_limit),
        .raw  (limit_raw)
    );

    function automatic logic [15:0] block_word(input logic [7:0] data_byte);
        return {data_byte, BLOCK_COUNT}; // RULE10
    endfunction

    function automatic logic is_block_cmd(input logic [7:0] c);
        return c == CMD_MAKER_ID || c == CMD_MODEL_ID || c == CMD_SERIAL_ID;
    endfunction

    // ========================================================
    // next state
    always_comb begin
        st_d          = st_q;
        st_d.rd_valid = 1'b0;
        st_d.unmapped = 1'b0;
        st_d.refused  = 1'b0;
        st_d.fault_s1 = nvm_fault_pin;
        st_d.fault_s2 = st_q.fault_s1;
        st_d.done_s1  = startup_done;
        st_d.done_s2  = st_q.done_s1;

        // sticky until reset; only sampled during start-up
        if (st_q.fault_s2 && !st_q.done_s2) begin
            st_d.nvm_fault = 1'b1; // RULE8
        end

        if (avg_current_valid) begin
            st_d.avg_oc_fault = avg_current > limit_raw; // RULE2
        end

        if (wr_en) begin
            if (is_block_cmd(cmd) && wr_data[7:0] != BLOCK_COUNT) begin
                st_d.refused = 1'b1; // RULE10
            end else begin
                unique case (cmd)
                    CMD_STARTUP_TIMEOUT_ACTION: st_d.startup_timeout_action = wr_data[7:0];
                    CMD_POWER_DOWN_DELAY:       st_d.power_down_delay       = wr_data;
                    CMD_POWER_DOWN_RAMP:        st_d.power_down_ramp        = wr_data;
                    CMD_AVG_OC_ACTION:          st_d.avg_oc_action          = wr_data[7:0];
                    CMD_AVG_OC_LIMIT:           st_d.avg_oc_limit           = wr_data; // RULE2
                    CMD_PCT_VOUT_LIMITS:        st_d.pct_vout_limits        = wr_data;
                    CMD_PCT_PGOOD:              st_d.pct_pgood              = wr_data[7:0];
                    CMD_VENDOR_MODE:            st_d.vendor_mode            = wr_data[7:0]; // RULE3
                    CMD_BUS_BASE_ADDRESS:       st_d.base_address           = wr_data[6:0]; // RULE1
                    CMD_MAKER_ID:               st_d.maker_id               = wr_data[15:8];
                    CMD_MODEL_ID:               st_d.model_id               = wr_data[15:8];
                    CMD_SERIAL_ID:              st_d.serial_id              = wr_data[15:8];
                    CMD_SECOND_MAKER_ID:        st_d.second_maker_id        = wr_data; // RULE9
                    CMD_STATUS_BYTE, CMD_STATUS_WORD, CMD_VOUT_STATUS, CMD_IOUT_STATUS,
                    CMD_INPUT_STATUS, CMD_TEMP_STATUS, CMD_CML_STATUS, CMD_VENDOR_STATUS,
                    CMD_VIN_READING, CMD_IIN_READING, CMD_VOUT_READING, CMD_IOUT_READING,
                    CMD_TEMP_READING, CMD_FREQ_READING, CMD_PROTOCOL_REVISION,
                    CMD_MAKER_REVISION, CMD_MIN_VOUT, CMD_MAX_VOUT, CMD_CHIP_ID,
                    CMD_CHIP_REVISION:          st_d.refused = 1'b1; // RULE11
                    default:                    st_d.unmapped = 1'b1;
                endcase
            end
        end else if (rd_en) begin
            st_d.rd_valid = 1'b1;
            st_d.rd_data  = 16'h0000;
            unique case (cmd)
                CMD_STARTUP_TIMEOUT_ACTION: st_d.rd_data = {8'h00, st_q.startup_timeout_action};
                CMD_POWER_DOWN_DELAY:       st_d.rd_data = st_q.power_down_delay;
                CMD_POWER_DOWN_RAMP:        st_d.rd_data = st_q.power_down_ramp;
                CMD_STATUS_BYTE:            st_d.rd_data = {8'h00, status_byte_in};
                CMD_STATUS_WORD:            st_d.rd_data = status_word_in;
                CMD_VOUT_STATUS:            st_d.rd_data = {8'h00, vout_status_in};
                CMD_IOUT_STATUS:            st_d.rd_data = {8'h00, iout_status_in};
                CMD_INPUT_STATUS:           st_d.rd_data = {8'h00, input_status_in};
                CMD_TEMP_STATUS:            st_d.rd_data = {8'h00, temp_status_in};
                CMD_CML_STATUS:             st_d.rd_data = {8'h00, cml_status_in};
                CMD_VENDOR_STATUS:
                    st_d.rd_data = 16'(st_q.nvm_fault) << VSTAT_NVM_FAULT_BIT; // RULE8
                CMD_VIN_READING:            st_d.rd_data = vin_reading;
                CMD_IIN_READING:            st_d.rd_data = iin_reading;
                CMD_VOUT_READING:           st_d.rd_data = vout_reading;
                CMD_IOUT_READING:           st_d.rd_data = iout_reading;
                CMD_TEMP_READING:           st_d.rd_data = temp_reading;
                CMD_FREQ_READING:           st_d.rd_data = freq_reading;
                CMD_PROTOCOL_REVISION:      st_d.rd_data = {8'h00, ID_PROTOCOL_REVISION};
                CMD_MAKER_ID:               st_d.rd_data = block_word(st_q.maker_id);
                CMD_MODEL_ID:               st_d.rd_data = block_word(st_q.model_id);
                CMD_MAKER_REVISION:         st_d.rd_data = block_word(ID_DATA_BYTE);
                CMD_SERIAL_ID:              st_d.rd_data = block_word(st_q.serial_id);
                CMD_MIN_VOUT:               st_d.rd_data = RST_MIN_VOUT;
                CMD_MAX_VOUT:               st_d.rd_data = RST_MAX_VOUT;
                CMD_CHIP_ID:                st_d.rd_data = block_word(ID_DATA_BYTE);
                CMD_CHIP_REVISION:          st_d.rd_data = block_word(ID_DATA_BYTE);
                CMD_AVG_OC_ACTION:          st_d.rd_data = {8'h00, st_q.avg_oc_action};
                CMD_AVG_OC_LIMIT:           st_d.rd_data = st_q.avg_oc_limit;
                CMD_PCT_VOUT_LIMITS:        st_d.rd_data = st_q.pct_vout_limits;
                CMD_PCT_PGOOD:              st_d.rd_data = {8'h00, st_q.pct_pgood};
                CMD_VENDOR_MODE:            st_d.rd_data = {8'h00, st_q.vendor_mode};
                CMD_BUS_BASE_ADDRESS:       st_d.rd_data = {9'h000, st_q.base_address}; // RULE1
                CMD_SECOND_MAKER_ID:        st_d.rd_data = st_q.second_maker_id; // RULE9
                default:                    st_d.unmapped = 1'b1;
            endcase
        end
    end

    // ========================================================
    // registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q                        <= '0;
            st_q.startup_timeout_action <= RST_STARTUP_TIMEOUT_ACTION;
            st_q.power_down_delay       <= RST_POWER_DOWN_DELAY;
            st_q.power_down_ramp        <= RST_POWER_DOWN_RAMP;
            st_q.avg_oc_action          <= RST_AVG_OC_ACTION;
            st_q.avg_oc_limit           <= RST_AVG_OC_LIMIT;
            st_q.pct_vout_limits        <= RST_PCT_VOUT_LIMITS;
            st_q.pct_pgood              <= RST_PCT_PGOOD;
            st_q.vendor_mode            <= RST_VENDOR_MODE; // RULE3
            st_q.base_address           <= RST_BUS_BASE_ADDRESS; // RULE1
            st_q.maker_id               <= ID_DATA_BYTE;
            st_q.model_id               <= ID_DATA_BYTE;
            st_q.serial_id              <= ID_DATA_BYTE;
            st_q.second_maker_id        <= ID_SECOND_MAKER;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // outputs
    assign rd_data                       = st_q.rd_data;
    assign rd_valid                      = st_q.rd_valid;
    assign cmd_unmapped                  = st_q.unmapped;
    assign wr_refused                    = st_q.refused;
    assign alert_output_n                = ~st_q.nvm_fault; // RULE8
    assign avg_overcurrent_fault         = st_q.avg_oc_fault;
    assign avg_overcurrent_action        = st_q.avg_oc_action;
    assign startup_timeout_fault_action  = st_q.startup_timeout_action;
    assign power_down_delay              = st_q.power_down_delay;
    assign power_down_ramp_time          = st_q.power_down_ramp;
    assign percent_output_voltage_limits = st_q.pct_vout_limits;
    assign percent_power_good_thresholds = st_q.pct_pgood;
    assign voltage_set_pin_select        = st_q.vendor_mode[MODE_VOLTAGE_SET_PIN_BIT]; // RULE3
    assign low_side_switch_at_overvoltage_warning = st_q.vendor_mode[MODE_LSW_OVW_BIT]; // RULE4
    assign discontinuous_conduction      = st_q.vendor_mode[MODE_DCM_BIT]; // RULE4
    assign input_current_sense_resistor  = st_q.vendor_mode[MODE_RSENSE_LSB +: 4]; // RULE5
    assign bus_base_address              = st_q.base_address;

    // ========================================================
    // checks
    AST_BASE_WRITE: assert property (@(posedge clk) disable iff (!rstn) // RULE1
        wr_en && cmd == CMD_BUS_BASE_ADDRESS |=> bus_base_address == $past(wr_data[6:0]))
        else $error("base address not written");
    AST_OC_FAULT: assert property (@(posedge clk) disable iff (!rstn) // RULE2
        avg_current_valid && avg_current > limit_raw |=> avg_overcurrent_fault)
        else $error("average overcurrent missed");
    AST_VOLTAGE_SET_PIN: assert property (@(posedge clk) disable iff (!rstn) // RULE3
        wr_en && cmd == CMD_VENDOR_MODE |=> voltage_set_pin_select == $past(wr_data[0]))
        else $error("voltage-set select wrong");
    AST_LSW: assert property (@(posedge clk) disable iff (!rstn) // RULE4
        wr_en && cmd == CMD_VENDOR_MODE |=> low_side_switch_at_overvoltage_warning
            == $past(wr_data[1]) && discontinuous_conduction == $past(wr_data[2]))
        else $error("mode controls wrong");
    AST_RSENSE: assert property (@(posedge clk) disable iff (!rstn) // RULE5
        wr_en && cmd == CMD_VENDOR_MODE |=> input_current_sense_resistor == $past(wr_data[7:4]))
        else $error("sense resistor field wrong");
    AST_NVM_ALERT: assert property (@(posedge clk) disable iff (!rstn) // RULE8
        nvm_fault_pin && !startup_done ##1 nvm_fault_pin && !startup_done
            |=> ##1 !alert_output_n)
        else $error("alert not asserted on memory fault");
    AST_ID2: assert property (@(posedge clk) disable iff (!rstn) // RULE9
        wr_en && cmd == CMD_SECOND_MAKER_ID |=> st_q.second_maker_id == $past(wr_data))
        else $error("second maker id lost bits");
    AST_BLOCK_COUNT: assert property (@(posedge clk) disable iff (!rstn) // RULE10
        rd_en && !wr_en && is_block_cmd(cmd) |=> rd_data[7:0] == BLOCK_COUNT)
        else $error("block count not 01h");
    AST_RO: assert property (@(posedge clk) disable iff (!rstn) // RULE11
        wr_en && cmd == CMD_MIN_VOUT |=> wr_refused)
        else $error("read-only write not refused");
endmodule // power_management_command_bank

// [tb/pm_host.sv]
`timescale 1ns/100ps
// ==========================================
// host model on the management bus
module pm_host (
    input  wire logic        clk,
    output logic             wr_en,
    output logic             rd_en,
    output logic [7:0]       cmd,
    output logic [15:0]      wr_data,
    input  wire logic [15:0] rd_data
);
    logic reg_on = 1'b1;
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        cmd = 8'h00;
        wr_data = 16'h0000;
    end
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q);
        if (w) reg_on = 1'b0;
        @(posedge clk);
        #1;
        wr_en = w;
        rd_en = !w;
        cmd = c;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        cmd = ~c;
        wr_data = ~d;
        q = rd_data;
    endtask
endmodule // pm_host

// [tb/power_management_command_bank_tb.sv]
`timescale 1ns/100ps
module power_management_command_bank_tb;
    import pmbank_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, nvm = 1'b0, done = 1'b0, avg_v = 1'b0;
    logic [15:0] avg = 16'h0000, tele = 16'hC3A5, q, wr_data, rd_data;
    logic        wr_en, rd_en, rd_valid, unm, refd, alert_n, fault, vsel, lsw, dcm;
    logic [7:0]  cmd;
    logic [6:0]  base;
    logic [3:0]  rsense;
    logic [7:0]  oca, sta, pg;
    logic [15:0] pdd, pdr, pcl;
    int          miscompares = 0, n_checks = 0;
    // ==========================================
    // structure
    pm_host pm_host_inst (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .cmd(cmd),
        .wr_data(wr_data), .rd_data(rd_data));
    power_management_command_bank power_management_command_bank_inst (
        .clk(clk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en), .cmd(cmd),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .cmd_unmapped(unm), .wr_refused(refd), .nvm_fault_pin(nvm),
        .startup_done(done), .avg_current(avg), .avg_current_valid(avg_v),
        .status_byte_in(tele[7:0]), .status_word_in(tele), .vout_status_in(tele[7:0]),
        .iout_status_in(tele[7:0]), .input_status_in(tele[7:0]),
        .temp_status_in(tele[7:0]), .cml_status_in(tele[7:0]), .vin_reading(tele),
        .iin_reading(tele), .vout_reading(tele), .iout_reading(tele),
        .temp_reading(tele), .freq_reading(tele), .alert_output_n(alert_n),
        .avg_overcurrent_fault(fault), .avg_overcurrent_action(oca),
        .startup_timeout_fault_action(sta), .power_down_delay(pdd), .power_down_ramp_time(pdr),
        .percent_output_voltage_limits(pcl), .percent_power_good_thresholds(pg),
        .voltage_set_pin_select(vsel), .low_side_switch_at_overvoltage_warning(lsw),
        .discontinuous_conduction(dcm), .input_current_sense_resistor(rsense),
        .bus_base_address(base));
    // ==========================================
    // helpers
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic pulse_avg(input logic [15:0] v);
        @(posedge clk);
        #1;
        avg = v;
        avg_v = 1'b1;
        @(posedge clk);
        #1;
        avg_v = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset_values();
        logic [7:0]  c [11] = '{8'h63, 8'h64, 8'h65, 8'hA4, 8'hA5, 8'hC4, 8'hC5, 8'hC6,
                                8'hC7, 8'hC8, 8'hC9};
        logic [15:0] e [11] = '{16'h0080, 16'h0000, 16'h0005, 16'h0100, 16'h0B01,
                                16'h0080, 16'hE340, 16'h06E0, 16'h0019, 16'h00A0, 16'h0010};
        chk("alert idle", {15'h0, alert_n}, 16'h0001);
        chk("base pins", {9'h0, base}, 16'h0010);
        chk("mode pins", {9'h0, rsense, dcm, lsw, vsel}, 16'h0050);
        chk("action pins", {oca, sta}, 16'h8080);
        chk("delay pins", pdd, 16'h0000);
        chk("ramp pins", pdr, 16'h0005);
        chk("pct pins", pcl, 16'h06E0);
        chk("pgood pins", {8'h00, pg}, 16'h0019);
        for (int i = 0; i < 11; i++) begin
            pm_host_inst.xfer(1'b0, c[i], 16'h0000, q);
            chk("read valid", {15'h0, rd_valid}, 16'h0001);
            chk("reset value", q, e[i]);
        end
    endtask
    task automatic t_config();
        pm_host_inst.xfer(1'b1, 8'hC9, 16'h005A, q);
        pm_host_inst.xfer(1'b0, 8'hC9, 16'h0000, q);
        chk("base read", q, 16'h005A);
        chk("base pins", {9'h0, base}, 16'h005A);
        pm_host_inst.xfer(1'b1, 8'hC8, 16'h0037, q);
        chk("mode on", {9'h0, rsense, dcm, lsw, vsel}, 16'h001F);
        pm_host_inst.xfer(1'b1, 8'hC8, 16'h00C0, q);
        chk("mode off", {9'h0, rsense, dcm, lsw, vsel}, 16'h0060);
    endtask
    task automatic t_readonly();
        logic [7:0] c [13] = '{8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h79, 8'h88,
                               8'h89, 8'h8B, 8'h8C, 8'h8D, 8'h95};
        for (int i = 0; i < 13; i++) begin
            pm_host_inst.xfer(1'b1, c[i], ~tele, q);
            chk("ro refused", {15'h0, refd}, 16'h0001);
            pm_host_inst.xfer(1'b0, c[i], 16'h0000, q);
            chk("ro value", q, (i < 6) ? {8'h00, tele[7:0]} : tele);
        end
        pm_host_inst.xfer(1'b1, 8'hA4, 16'hFFFF, q);
        chk("ro min refused", {15'h0, refd}, 16'h0001);
        pm_host_inst.xfer(1'b0, 8'hA4, 16'h0000, q);
        chk("ro min value", q, 16'h0100);
    endtask
    task automatic t_ident();
        logic [7:0] c [3] = '{8'h9B, 8'hAD, 8'hAE};
        foreach (c[i]) begin
            pm_host_inst.xfer(1'b0, c[i], 16'h0000, q);
            chk("block count", {8'h00, q[7:0]}, 16'h0001);
        end
        pm_host_inst.xfer(1'b1, 8'h99, 16'h3C02, q);
        chk("bad count", {15'h0, refd}, 16'h0001);
        pm_host_inst.xfer(1'b0, 8'h99, 16'h0000, q);
        chk("block kept", q, {ID_DATA_BYTE, 8'h01});
        pm_host_inst.xfer(1'b1, 8'h99, 16'h3C01, q);
        chk("good count", {15'h0, refd}, 16'h0000);
        pm_host_inst.xfer(1'b0, 8'h99, 16'h0000, q);
        chk("block new", q, 16'h3C01);
        pm_host_inst.xfer(1'b1, 8'hCA, 16'hA5C3, q);
        pm_host_inst.xfer(1'b0, 8'hCA, 16'h0000, q);
        chk("word id", q, 16'hA5C3);
        pm_host_inst.xfer(1'b0, 8'h70, 16'h0000, q);
        chk("unmapped", {15'h0, unm}, 16'h0001);
    endtask
    task automatic t_overcurrent();
        pulse_avg(16'h0340);
        chk("at limit", {15'h0, fault}, 16'h0000);
        pulse_avg(16'h0341);
        chk("over limit", {15'h0, fault}, 16'h0001);
    endtask
    task automatic t_memory_fault();
        nvm = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("alert low", {15'h0, alert_n}, 16'h0000);
        pm_host_inst.xfer(1'b0, 8'h80, 16'h0000, q);
        chk("fault bit", {15'h0, q[1]}, 16'h0001);
        done = 1'b1;
    endtask
    // ==========================================
    // run
    initial forever #10 clk = ~clk;
    initial begin
        #200_000;
        miscompares++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_reset_values();
        t_config();
        t_readonly();
        t_ident();
        t_overcurrent();
        t_memory_fault();
        close_out();
    end
endmodule // power_management_command_bank_tb
